// file: rtl/pulse_div_pkg.sv
// Purpose: shared constants and carriers for the pulse divider output block
// Assumes: one 200 MHz core clock, plain register port
// Notes: register offsets are word indices on the plain port
package pulse_div_pkg;
  // register map
  localparam logic [3:0] OFS_MODE = 4'h0;
  localparam logic [3:0] OFS_NUM = 4'h1;
  localparam logic [3:0] OFS_DEN = 4'h2;
  localparam logic [3:0] OFS_STATUS = 4'h3;
  // reset values and register write limit
  localparam logic [7:0] MODE_RESET = 8'h01;
  localparam logic [31:0] NUM_RESET = 32'h0000_2710;
  localparam logic [31:0] DEN_RESET = 32'h0002_0000;
  localparam logic [31:0] RATIO_MAX = 32'h00c8_0000;
  // encoder counts per revolution after 4x
  localparam logic [31:0] COUNTS_PER_REV = 32'h0002_0000;
  // mode field positions
  localparam int SRC_LO = 0;
  localparam int PHASE_BIT = 2;
  localparam int ZPOL_BIT = 3;
  // source selection codes
  localparam logic [1:0] SRC_MOTOR = 2'h1;
  localparam logic [1:0] SRC_SECOND = 2'h2;
  localparam logic [1:0] SRC_BYPASS = 2'h3;
  // one feedback input channel: step pulse, direction, index
  typedef struct packed {
    logic step;
    logic dir;
    logic index;
  } feed_s;
  // quadrature output group
  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } quad_s;
endpackage : pulse_div_pkg

// file: rtl/ratio_accum.sv
// Purpose: fractional accumulator turning input counts into output steps
// Assumes: at most one input count per cycle
// Notes: output step issued in the cycle after its input count
`timescale 1ns/1ps
module ratio_accum (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // scaling
  input wire logic [31:0] num,
  input wire logic [31:0] den_eff,
  // input count
  input wire logic in_step,
  input wire logic in_dir,
  // output step
  output logic out_step,
  output logic out_dir
);
  // unsigned remainder, kept in [0, den_eff) while num does not exceed den_eff
  logic [33:0] acc_reg;
  logic [33:0] acc_sum;
  // add numerator per count; emit one step when the remainder wraps
  always_comb begin
    acc_sum = acc_reg + {2'h0, num};
  end
  // accumulator update, carries fraction forward
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      acc_reg <= 34'h0;
      out_step <= 1'b0;
      out_dir <= 1'b0;
    end else begin
      out_step <= 1'b0;
      if (in_step) begin
        out_dir <= in_dir;
        if (acc_sum >= {2'h0, den_eff}) begin
          acc_reg <= acc_sum - {2'h0, den_eff};
          out_step <= 1'b1;
        end else begin
          acc_reg <= acc_sum;
        end
      end
    end
  end
endmodule : ratio_accum

// file: rtl/pulse_div_out.sv
// Purpose: encoder pulse divider output with A/B quadrature and Z index
// Assumes: feedback arrives as one-cycle count pulses with direction
// Notes: ratio applied as num/den per input count, 131072 counts per rev
// How it works
// - mode codes 1,5,9,13 pick motor encoder
// - mode codes 2,6,10,14 pick second encoder
// - source 3 bypasses command pulses untouched
// - bit2 chooses A-leads-B or B-leads-A
// - bit3 chooses Z rising or falling mark
// - Z only from motor encoder outside bypass (source 3 passes command Z), quadrature A/B
// - edges per rev equal num/den times 131072
// - numerator above denominator gives numerator edges, at most 131072
// - numerator range 0..13107200, reset 10000
// - denominator range 0..13107200, reset 131072
`timescale 1ns/1ps
module pulse_div_out (
  // clock and reset
  input wire logic CORE_CLK,
  input wire logic RST_B,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [31:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [31:0] REG_RDATA,
  // feedback and command sources
  input wire pulse_div_pkg::feed_s MOTOR_FEED,
  input wire pulse_div_pkg::feed_s SECOND_FEED,
  input wire pulse_div_pkg::quad_s CMD_PULSE,
  // divided output toward the host counter
  output pulse_div_pkg::quad_s DIV_OUT
);
  import pulse_div_pkg::*;

  // configuration registers
  logic [7:0] mode_reg;
  logic [31:0] num_reg;
  logic [31:0] den_reg;
  // quadrature phase state and Z level
  logic [1:0] phase_reg;
  logic z_mark_reg;
  // decoded mode fields
  logic [1:0] src;
  logic phase_swap;
  logic z_fall;
  // selected input count
  logic sel_step;
  logic sel_dir;
  // effective divisor and accumulator output
  logic [31:0] den_eff;
  logic acc_step;
  logic acc_dir;
  // status: step count for software visibility
  logic [15:0] step_cnt_reg;

  // mode field decode
  always_comb begin
    src = mode_reg[SRC_LO +: 2];
    phase_swap = mode_reg[PHASE_BIT];
    z_fall = mode_reg[ZPOL_BIT];
  end

  // source mux for the divider path
  always_comb begin
    sel_step = 1'b0;
    sel_dir = 1'b0;
    unique case (src)
      SRC_MOTOR: begin
        sel_step = MOTOR_FEED.step;
        sel_dir = MOTOR_FEED.dir;
      end
      SRC_SECOND: begin
        sel_step = SECOND_FEED.step;
        sel_dir = SECOND_FEED.dir;
      end
      default: begin
        sel_step = 1'b0;
        sel_dir = 1'b0;
      end
    endcase
  end

  // divisor: num/den normally, num/131072 when num exceeds den
  always_comb begin
    if (num_reg > den_reg) begin
      den_eff = COUNTS_PER_REV;
    end else begin
      den_eff = den_reg;
    end
  end

  // fractional accumulator
  ratio_accum u_accum (
    .clk(CORE_CLK),
    .rst_b(RST_B),
    .num(num_reg),
    .den_eff(den_eff),
    .in_step(sel_step),
    .in_dir(sel_dir),
    .out_step(acc_step),
    .out_dir(acc_dir)
  );

  // mode register writes
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      mode_reg <= MODE_RESET;
    end else if (REG_WR && REG_ADDR == OFS_MODE) begin
      mode_reg <= REG_WDATA[7:0];
    end
  end

  // numerator writes, out-of-range values ignored
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      num_reg <= NUM_RESET;
    end else if (REG_WR && REG_ADDR == OFS_NUM && REG_WDATA <= RATIO_MAX) begin
      num_reg <= REG_WDATA;
    end
  end

  // denominator writes, out-of-range values ignored
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      den_reg <= DEN_RESET;
    end else if (REG_WR && REG_ADDR == OFS_DEN && REG_WDATA <= RATIO_MAX) begin
      den_reg <= REG_WDATA;
    end
  end

  // quadrature state advance, one step per accumulator pulse
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      phase_reg <= 2'h0;
    end else if (src != SRC_BYPASS && acc_step) begin
      if (acc_dir) begin
        phase_reg <= phase_reg - 2'h1;
      end else begin
        phase_reg <= phase_reg + 2'h1;
      end
    end
  end

  // Z index level, only for the motor encoder
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      z_mark_reg <= 1'b0;
    end else begin
      z_mark_reg <= (src == SRC_MOTOR) && MOTOR_FEED.index;
    end
  end

  // output stage: bypass, or gray-coded phase to A/B
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      DIV_OUT <= '0;
    end else if (src == SRC_BYPASS) begin
      DIV_OUT <= CMD_PULSE;
    end else begin
      // gray sequence ab 00,10,11,01 so a leads b when not swapped
      DIV_OUT.a <= phase_swap ? phase_reg[1] : phase_reg[0] ^ phase_reg[1];
      DIV_OUT.b <= phase_swap ? phase_reg[0] ^ phase_reg[1] : phase_reg[1];
      // falling mark: inverted index, still only for the motor source
      DIV_OUT.z <= z_fall ? (~z_mark_reg & (src == SRC_MOTOR)) : z_mark_reg;
    end
  end

  // status counter of output steps
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      step_cnt_reg <= 16'h0;
    end else if (acc_step && src != SRC_BYPASS) begin
      step_cnt_reg <= step_cnt_reg + 16'h1;
    end
  end

  // register read port, data in the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_B) begin
      REG_RDATA <= 32'h0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        OFS_MODE: REG_RDATA <= {24'h0, mode_reg};
        OFS_NUM: REG_RDATA <= num_reg;
        OFS_DEN: REG_RDATA <= den_reg;
        OFS_STATUS: REG_RDATA <= {14'h0, phase_reg, step_cnt_reg};
        default: REG_RDATA <= 32'h0;
      endcase
    end else begin
      REG_RDATA <= 32'h0;
    end
  end

  // checks
  a_bypass_copy: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    $past(src) == SRC_BYPASS && src == SRC_BYPASS |-> DIV_OUT == $past(CMD_PULSE))
    else $error("bypass output differs from command");
  a_z_source: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    src == SRC_SECOND |=> !z_mark_reg)
    else $error("z marked from wrong source");
  a_num_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    num_reg <= RATIO_MAX)
    else $error("numerator out of range");
  a_den_range: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    den_reg <= RATIO_MAX)
    else $error("denominator out of range");
  a_quad_step: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    acc_step && src != SRC_BYPASS && !acc_dir |=> phase_reg == $past(phase_reg) + 2'h1)
    else $error("phase did not advance");
  a_quad_back: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    acc_step && src != SRC_BYPASS && acc_dir |=> phase_reg == $past(phase_reg) - 2'h1)
    else $error("phase did not step back");
  a_quad_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !acc_step |=> phase_reg == $past(phase_reg))
    else $error("phase moved without step");
  a_big_num: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    num_reg > den_reg |-> den_eff == COUNTS_PER_REV)
    else $error("large numerator divisor wrong");
  a_read_latency: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    REG_RD && REG_ADDR == OFS_NUM |=> REG_RDATA == $past(num_reg))
    else $error("numerator readback wrong");
  c_motor_step: cover property (@(posedge CORE_CLK) src == SRC_MOTOR && acc_step);
  c_second_step: cover property (@(posedge CORE_CLK) src == SRC_SECOND && acc_step);
  c_bypass: cover property (@(posedge CORE_CLK) src == SRC_BYPASS && CMD_PULSE.a);
endmodule : pulse_div_out

// file: testbench/quad_counter.sv
// Purpose: host counter model watching the divided quadrature output
// Assumes: A leading B counts up, x4 decode
// Notes: every A and B edge moves the count by one
`timescale 1ns/1ps
module quad_counter (
  // clock
  input wire logic clk,
  // watched pulses
  input wire pulse_div_pkg::quad_s q,
  // running position
  output int pos
);
  import pulse_div_pkg::*;
  quad_s last_reg = '0; // previous sample, pos starts at zero as an int
  // x4 decode, direction from old A against new B
  always @(posedge clk) begin
    if ((q.a ^ last_reg.a) | (q.b ^ last_reg.b)) begin
      pos <= pos + ((last_reg.a ^ q.b) ? -1 : 1);
    end
    last_reg <= q;
  end
endmodule : quad_counter

// file: testbench/pulse_div_out_tb.sv
// Purpose: self-checking bench for the pulse divider output
// Assumes: host counter model on the divided output
// Notes: register rows first, then modes, ratios, bypass, reset
`timescale 1ns/1ps
module pulse_div_out_tb;
  import pulse_div_pkg::*;
  typedef struct packed {logic [3:0] a; logic [31:0] d; logic [31:0] e;} row_s;
  logic clk, rst_b, we, re;
  logic [3:0] addr;
  logic [31:0] wdata, rdata;
  feed_s motor, second;
  quad_s cmd, div_out;
  int pos, errors, tests_run, cycles;
  // write, then expected readback
  row_s rows [7] = '{'{4'h0, 32'hd, 32'hd}, '{4'h1, 32'hc80000, 32'hc80000},
    '{4'h1, 32'hc80001, 32'hc80000}, '{4'h2, 32'hc80000, 32'hc80000},
    '{4'h2, 32'hc80001, 32'hc80000}, '{4'hf, 32'h5, 32'h0}, '{4'h3, 32'h7, 32'h0}};
  int codes [8] = '{1, 5, 9, 13, 2, 6, 10, 14};
  pulse_div_out u_dut (.CORE_CLK(clk), .RST_B(rst_b), .REG_ADDR(addr), .REG_WDATA(wdata),
    .REG_WR(we), .REG_RD(re), .REG_RDATA(rdata), .MOTOR_FEED(motor),
    .SECOND_FEED(second), .CMD_PULSE(cmd), .DIV_OUT(div_out));
  quad_counter u_host (.clk(clk), .q(div_out), .pos(pos));
  // 200 MHz clock
  initial begin
    clk = 0;
    forever #2.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      test_done();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  // read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    @(posedge clk);
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask : rdchk
  // n one-cycle counts on both feeds, then check host movement
  task automatic move(input int n, input logic dm, input logic ds, input int e);
    int p0;
    repeat (4) @(posedge clk);
    p0 = pos;
    repeat (n) begin
      @(posedge clk);
      motor.step <= 1'b1;
      second.step <= 1'b1;
      motor.dir <= dm;
      second.dir <= ds;
      @(posedge clk);
      motor.step <= 1'b0;
      second.step <= 1'b0;
    end
    repeat (6) @(posedge clk);
    chk(32'(pos - p0), 32'(e));
  endtask : move
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // main sequence
  initial begin
    int e;
    {rst_b, we, re, addr, wdata, motor, second, cmd} = '0;
    {errors, tests_run, cycles} = '0;
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    // register rows, out-of-range and unmapped included
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rdchk(rows[i].a, rows[i].e);
    end
    $display("register rows done");
    // every motor and second-encoder mode code, motor forward and second reverse
    wr(4'h1, 32'h1);
    wr(4'h2, 32'h1);
    motor.index <= 1'b1;
    foreach (codes[i]) begin
      wr(4'h0, 32'(codes[i]));
      e = codes[i][0] ? 4 : -4;
      move(4, 1'b0, 1'b1, codes[i][2] ? -e : e);
      chk({31'h0, div_out.z}, {31'h0, codes[i][0] & ~codes[i][3]});
    end
    $display("mode codes done");
    // fractional ratio below one, numerator kept small
    wr(4'h0, 32'h1);
    wr(4'h1, 32'h1);
    wr(4'h2, 32'h2);
    move(8, 1'b0, 1'b0, 4);
    // numerator above denominator, edges per rev equal numerator
    wr(4'h1, 32'h10000);
    move(8, 1'b0, 1'b0, 4);
    $display("ratio tests done");
    // bypass, phase and polarity bits ignored
    wr(4'h0, 32'h3);
    cmd <= 3'b101;
    repeat (4) @(posedge clk);
    chk(32'(div_out), 32'h5);
    wr(4'h0, 32'hf);
    cmd <= 3'b010;
    repeat (4) @(posedge clk);
    chk(32'(div_out), 32'h2);
    $display("bypass done");
    // mid-run reset restores defaults
    rst_b <= 1'b0;
    @(posedge clk);
    rst_b <= 1'b1;
    rdchk(4'h0, 32'(MODE_RESET));
    rdchk(4'h1, NUM_RESET);
    rdchk(4'h2, DEN_RESET);
    chk(32'(div_out), 32'h1);
    $display("reset done");
    test_done();
  end
endmodule : pulse_div_out_tb
